// File: verilog/srs_top.sv
/*
 Start-up release sequencer with AHB-Lite register access.
 Assumes inputs synchronous to hclk; config_clock and test clock arrive
 as one-cycle enable pulses sampled in the hclk domain.
*/
`timescale 1ns/1ns
module srs_top #(
   parameter int NUM_LOCK = 8,
   parameter int RB_DEPTH = 64
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic config_clock,
   input wire logic test_clock,
   input wire logic shift_data_state,
   input wire logic [4:0] tap_instruction,
   input wire logic shared_done,
   input wire logic [NUM_LOCK-1:0] lock,
   output logic config_done,
   output logic clear_done,
   output logic global_output_float,
   output logic global_set_reset,
   output logic global_write_hold
);
   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] ctrl;
   logic [15:0] order;
   logic [$clog2(RB_DEPTH)-1:0] rb_addr;
   logic [31:0] rb_mem [RB_DEPTH];
   logic [31:0] next_rdata;
   logic [3:0] stage;
   logic step;
   logic stall;
   logic restart;
   logic started;
   logic lock_ok;
   logic lock_stall;
   logic sync_stall;
   logic step_src;
   logic startup_step_command;
   srs_pkg::srs_state_t state;
   wire logic access = hsel && hready && htrans == srs_pkg::HTRANS_NONSEQ;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= access && hwrite && hsize == srs_pkg::HSIZE_WORD;
         wr_addr <= haddr[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= srs_pkg::CTRL_RST;
         order <= srs_pkg::ORDER_RST;
         rb_addr <= '0;
      end else begin
         // Self-clear first, so a write in the same cycle still wins
         if (restart) begin
            ctrl[srs_pkg::CTRL_CLEAR_BIT] <= 1'b0;
         end
         if (wr_pend) begin
            case (wr_addr)
               srs_pkg::CTRL_OFS: ctrl <= hwdata;
               srs_pkg::ORDER_OFS: order <= hwdata[15:0];
               srs_pkg::RB_ADDR_OFS: rb_addr <= hwdata[$clog2(RB_DEPTH)-1:0];
               default: ;
            endcase
         end
      end
   end

   // Readback image: loaded by software, stands in for config and storage
   always_ff @(posedge hclk) begin
      if (wr_pend && wr_addr == srs_pkg::RB_DATA_OFS) begin
         rb_mem[rb_addr] <= hwdata;
      end
   end

   // Read data registered in the address phase, presented in data phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr[7:0])
         srs_pkg::CTRL_OFS: next_rdata = ctrl;
         srs_pkg::ORDER_OFS: next_rdata = {16'h0000, order};
         srs_pkg::STATUS_OFS: next_rdata = {20'h0, stage, state, global_write_hold,
            global_set_reset, global_output_float, clear_done, config_done, lock_ok};
         srs_pkg::RB_ADDR_OFS: next_rdata = 32'(rb_addr);
         srs_pkg::RB_DATA_OFS: next_rdata = rb_mem[rb_addr];
         srs_pkg::TAP_OFS: next_rdata = {27'h0, tap_instruction};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (access && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Configuration phases
   // ----------------------------------------------------------------
   assign restart = ctrl[srs_pkg::CTRL_CLEAR_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= srs_pkg::SRS_CLEAR;
      end else if (restart) begin
         state <= srs_pkg::SRS_CLEAR;
      end else begin
         unique case (state)
            srs_pkg::SRS_CLEAR: state <= srs_pkg::SRS_LOAD;
            srs_pkg::SRS_LOAD: begin
               if (ctrl[srs_pkg::CTRL_LOAD_BIT]) begin
                  state <= srs_pkg::SRS_START;
               end
            end
            srs_pkg::SRS_START: begin
               if (stage >= order[srs_pkg::ORDER_DONE_LSB +: 4] && !lock_stall) begin
                  state <= srs_pkg::SRS_RUN;
               end
            end
            srs_pkg::SRS_RUN: ;
         endcase
      end
   end

   assign clear_done = state != srs_pkg::SRS_CLEAR;
   assign config_done = state == srs_pkg::SRS_RUN;

   // ----------------------------------------------------------------
   // Start-up stepping
   // ----------------------------------------------------------------
   // Test instruction must be loaded and in shift state to step from the test clock
   assign startup_step_command = tap_instruction == srs_pkg::START_STEP_CODE &&
      shift_data_state;
   // One step source, so sequencing and running stages always agree
   assign step_src = ctrl[srs_pkg::CTRL_TCLK_BIT] ? (test_clock && startup_step_command) :
      config_clock;
   assign step = state == srs_pkg::SRS_START && step_src;
   assign started = ctrl[srs_pkg::CTRL_LOAD_BIT];
   assign lock_ok = ctrl[srs_pkg::CTRL_LOCK_ALL_BIT] ?
      &(lock | ~ctrl[srs_pkg::CTRL_LOCK_MASK_LSB +: NUM_LOCK]) :
      |(lock & ctrl[srs_pkg::CTRL_LOCK_MASK_LSB +: NUM_LOCK]);
   // Lock wait also holds back done, so completion is delayed
   assign lock_stall = ctrl[srs_pkg::CTRL_LOCK_BIT] && !lock_ok &&
      stage == ctrl[srs_pkg::CTRL_LOCK_STAGE_LSB +: 4];
   assign sync_stall = ctrl[srs_pkg::CTRL_SYNC_BIT] && !shared_done &&
      stage >= order[srs_pkg::ORDER_DONE_LSB +: 4];
   assign stall = lock_stall || sync_stall;

   srs_stage_ctr #(
      .W(4)
   ) u_ctr (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(restart || !started),
      .step(step || (state == srs_pkg::SRS_RUN && step_src)),
      .stall(stall),
      .stage(stage)
   );

   // ----------------------------------------------------------------
   // Global release outputs
   // ----------------------------------------------------------------
   // Releases compare stage against order; with sync, done must be high
   function automatic logic held(input logic [3:0] at);
      held = !(state == srs_pkg::SRS_RUN && !restart && stage >= at &&
         (!ctrl[srs_pkg::CTRL_SYNC_BIT] || shared_done));
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_output_float <= 1'b1;
         global_set_reset <= 1'b1;
         global_write_hold <= 1'b1;
      end else begin
         global_output_float <= held(order[srs_pkg::ORDER_FLOAT_LSB +: 4]);
         global_set_reset <= held(order[srs_pkg::ORDER_RESET_LSB +: 4]);
         global_write_hold <= held(order[srs_pkg::ORDER_WHOLD_LSB +: 4]);
      end
   end
endmodule

// File: verilog/srs_pkg.sv
/*
 Constants for the start-up release sequencer: register map, field
 positions, reset values and the start-step test instruction code.
 Assumes a single AHB-Lite slave with 32-bit data, one word per register.
*/
package srs_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ORDER_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] RB_ADDR_OFS = 8'h0c;
   localparam logic [7:0] RB_DATA_OFS = 8'h10;
   localparam logic [7:0] TAP_OFS = 8'h14;
   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int CTRL_SYNC_BIT = 0;
   localparam int CTRL_LOCK_BIT = 1;
   localparam int CTRL_LOCK_ALL_BIT = 2;
   localparam int CTRL_TCLK_BIT = 3;
   localparam int CTRL_CLEAR_BIT = 4;
   localparam int CTRL_LOAD_BIT = 5;
   localparam int CTRL_LOCK_STAGE_LSB = 8;
   localparam int CTRL_LOCK_MASK_LSB = 16;
   // Order fields: release stage of float, set/reset, write hold
   localparam int ORDER_FLOAT_LSB = 0;
   localparam int ORDER_RESET_LSB = 4;
   localparam int ORDER_WHOLD_LSB = 8;
   localparam int ORDER_DONE_LSB = 12;
   // ----------------------------------------------------------------
   // Reset values, instruction and bus codes, state type
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] ORDER_RST = 16'h0221;
   localparam logic [4:0] START_STEP_CODE = 5'h0c;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic [1:0] {SRS_CLEAR, SRS_LOAD, SRS_START, SRS_RUN} srs_state_t;
endpackage

// File: verilog/srs_stage_ctr.sv
/*
 Start-up stage counter. Advances one stage per step while not stalled.
 Assumes step is a one-cycle pulse in the hclk domain.
*/
`timescale 1ns/1ns
module srs_stage_ctr #(
   parameter int W = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   input wire logic step,
   input wire logic stall,
   output logic [W-1:0] stage
);
   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Saturates so a long wait cannot wrap back into early stages
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage <= '0;
      end else if (clear) begin
         stage <= '0;
      end else if (step && !stall && stage != {W{1'b1}}) begin
         stage <= stage + 1'b1;
      end
   end
endmodule

// File: test/srs_partner.sv
/*
 Far-side model: configuration clock steps, wired done of the other
 devices and loop lock levels. Assumes the bench sets period and levels.
*/
`timescale 1ns/1ns
module srs_partner (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] period,
   input wire logic others_up,
   input wire logic lock_up,
   output logic config_clock,
   output logic shared_done,
   output logic [7:0] lock
);
   logic [3:0] cnt;
   // Period 1 gives prompt steps, larger values a slow source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 4'h0;
         config_clock <= 1'b0;
         shared_done <= 1'b0;
         lock <= 8'h00;
      end else begin
         cnt <= (cnt >= period) ? 4'h0 : cnt + 4'h1;
         config_clock <= (cnt == period);
         shared_done <= others_up;
         lock <= {8{lock_up}};
      end
   end
endmodule

// File: test/srs_top_props.sv
/*
 Checker on the sequencer's ports. Assumes one hclk domain, reset low.
*/
`timescale 1ns/1ns
module srs_top_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic config_done,
   input wire logic clear_done,
   input wire logic global_output_float,
   input wire logic global_set_reset,
   input wire logic global_write_hold
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_hold;
      !config_done |-> global_output_float && global_set_reset && global_write_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("control released early");
   property p_float_at_done;
      $rose(config_done) |-> global_output_float;
   endproperty
   a_float_at_done: assert property (p_float_at_done) else $error("float dropped with done");
   property p_float_late;
      $fell(global_output_float) |-> config_done && $past(config_done);
   endproperty
   a_float_late: assert property (p_float_late) else $error("float dropped too soon");
   property p_reset_late;
      $fell(global_set_reset) |-> $past(config_done);
   endproperty
   a_reset_late: assert property (p_reset_late) else $error("set reset dropped too soon");
   property p_whold_late;
      $fell(global_write_hold) |-> $past(config_done);
   endproperty
   a_whold_late: assert property (p_whold_late) else $error("write hold dropped too soon");
   property p_clear_first;
      config_done |-> clear_done;
   endproperty
   a_clear_first: assert property (p_clear_first) else $error("done without clear");
   // Zero-wait slave, so a stall here would hang the master
   property p_zero_wait;
      hreadyout;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("slave inserted wait");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
endmodule
bind srs_top srs_top_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .config_done,
   .clear_done, .global_output_float, .global_set_reset, .global_write_hold);

// File: test/startup_release_sequencer_tb.sv
/*
 Self-checking bench for the start-up release sequencer.
 Assumes srs_top, srs_partner and the bound checker are compiled first.
*/
`timescale 1ns/1ns
module startup_release_sequencer_tb;
   localparam int RBD = 16;
   logic hclk, hresetn, hsel, hwrite, others_up, lock_up, test_clock, shift_data_state;
   logic [31:0] haddr, hwdata, rd, seed, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] period;
   logic [4:0] tap_instruction;
   logic hreadyout, hresp, config_done, clear_done, config_clock, shared_done;
   logic global_output_float, global_set_reset, global_write_hold;
   logic [7:0] lock;
   int error_cnt = 0, checked = 0, cyc = 0;
   srs_top #(.RB_DEPTH(RBD)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .config_clock, .test_clock,
      .shift_data_state, .tap_instruction, .shared_done, .lock, .config_done, .clear_done,
      .global_output_float, .global_set_reset, .global_write_hold);
   srs_partner u_far (.hclk, .hresetn, .period, .others_up, .lock_up, .config_clock,
      .shared_done, .lock);
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   function automatic logic [31:0] nxt();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] order_of(input logic [3:0] f, g, w, d);
      return (32'(f) << srs_pkg::ORDER_FLOAT_LSB) | (32'(g) << srs_pkg::ORDER_RESET_LSB) |
         (32'(w) << srs_pkg::ORDER_WHOLD_LSB) | (32'(d) << srs_pkg::ORDER_DONE_LSB);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d = 32'h0);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= srs_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Clear first so each scenario starts from a held device
   task automatic run(input logic [31:0] ctrl, order);
      bus(1'b1, 32'(srs_pkg::CTRL_OFS), 32'h1 << srs_pkg::CTRL_CLEAR_BIT);
      repeat (20) if (config_done !== 1'b0) @(posedge hclk);
      chk("held", 3'h7, {global_output_float, global_set_reset, global_write_hold});
      bus(1'b1, 32'(srs_pkg::ORDER_OFS), order);
      bus(1'b1, 32'(srs_pkg::CTRL_OFS), ctrl | (32'h1 << srs_pkg::CTRL_LOAD_BIT));
   endtask
   task automatic pulses();
      repeat (8) begin
         @(posedge hclk);
         test_clock <= 1'b1;
         @(posedge hclk);
         test_clock <= 1'b0;
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      logic [31:0] a, d;
      {hresetn, hsel, hwrite, others_up, lock_up, test_clock, shift_data_state} = '0;
      {haddr, hwdata, htrans, tap_instruction} = '0;
      hsize = srs_pkg::HSIZE_WORD;
      period = 4'h2;
      seed = 32'd98221;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 32'(srs_pkg::ORDER_OFS));
      chk("order reset", 32'(srs_pkg::ORDER_RST), rd);
      bus(1'b0, 32'(srs_pkg::CTRL_OFS));
      chk("ctrl reset", srs_pkg::CTRL_RST, rd);
      bus(1'b0, 32'h40);
      chk("unmapped", 32'h0, rd);
      // Held controls, clear done, state load, stage zero
      bus(1'b0, 32'(srs_pkg::STATUS_OFS));
      chk("status", 32'h0000_007c, rd);
      chk("clear done", 1'b1, clear_done);
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? RBD - 1 : nxt() % RBD;
         d = nxt();
         bus(1'b1, 32'(srs_pkg::RB_ADDR_OFS), a);
         bus(1'b1, 32'(srs_pkg::RB_DATA_OFS), d);
         bus(1'b0, 32'(srs_pkg::RB_DATA_OFS));
         chk("readback", d, rd);
      end
      period <= 4'(nxt() % 4 + 1);
      run(32'h0, 32'(srs_pkg::ORDER_RST));
      repeat (300) if (config_done !== 1'b1) @(posedge hclk);
      chk("float at done", 1'b1, global_output_float);
      repeat (300) if (global_output_float !== 1'b0) @(posedge hclk);
      chk("after float", 3'h3, {global_output_float, global_set_reset, global_write_hold});
      repeat (300) if (global_set_reset !== 1'b0) @(posedge hclk);
      chk("after set reset", 3'h0, {global_output_float, global_set_reset, global_write_hold});
      run(32'h0, order_of(4'h3, 4'h1, 4'h2, 4'h1));
      repeat (300) if (global_set_reset !== 1'b0) @(posedge hclk);
      chk("set reset first", 3'h5, {global_output_float, global_set_reset, global_write_hold});
      repeat (300) if (global_write_hold !== 1'b0) @(posedge hclk);
      chk("write hold next", 3'h4, {global_output_float, global_set_reset, global_write_hold});
      run(32'h1 << srs_pkg::CTRL_SYNC_BIT, 32'(srs_pkg::ORDER_RST));
      repeat (40) @(posedge hclk);
      chk("sync wait", 3'h7, {global_output_float, global_set_reset, global_write_hold});
      others_up <= 1'b1;
      repeat (300) if (global_write_hold !== 1'b0) @(posedge hclk);
      chk("sync start", 3'h0, {global_output_float, global_set_reset, global_write_hold});
      for (int k = 0; k < 2; k++) begin
         lock_up <= 1'b0;
         run((32'h1 << srs_pkg::CTRL_LOCK_BIT) | (32'(k) << srs_pkg::CTRL_LOCK_ALL_BIT) |
            (32'h03 << srs_pkg::CTRL_LOCK_MASK_LSB), 32'(srs_pkg::ORDER_RST));
         repeat (40) @(posedge hclk);
         chk("lock stall", 1'b0, config_done);
         lock_up <= 1'b1;
         repeat (300) if (config_done !== 1'b1) @(posedge hclk);
         chk("lock go", 1'b1, config_done);
      end
      run(32'h1 << srs_pkg::CTRL_TCLK_BIT, 32'(srs_pkg::ORDER_RST));
      shift_data_state <= 1'b1;
      tap_instruction <= 5'h04;
      pulses();
      // Done needs no step at the default order, so watch the releases
      chk("bad instr", 3'h7, {global_output_float, global_set_reset, global_write_hold});
      tap_instruction <= srs_pkg::START_STEP_CODE;
      pulses();
      repeat (300) if (global_write_hold !== 1'b0) @(posedge hclk);
      chk("tclk start", 3'h0, {global_output_float, global_set_reset, global_write_hold});
      bus(1'b0, 32'(srs_pkg::TAP_OFS));
      chk("tap", 32'(srs_pkg::START_STEP_CODE), rd);
      conclude();
   end
endmodule
